// *** inc/mcu_decode_pkg.sv ***
// constants, encodings and types shared by the instruction decoder
package mcu_decode_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and reset values
  localparam int          PC_W      = 12;       // program memory address width
  localparam logic [11:0] PC_RST    = 12'h000;  // program counter after reset
  localparam logic [7:0]  ACC_RST   = 8'h00;    // accumulator after reset
  localparam logic [7:0]  DM_RST    = 8'h00;    // data memory after reset
  localparam logic [7:0]  CNT_RST   = 8'h00;    // timer/counter after reset
  localparam logic [7:0]  CNT_TOP   = 8'hff;    // count that overflows next tick
  localparam logic [3:0]  FIXED_PG  = 4'h3;     // page read by the fixed-page lookup

  ////////////////////////////////////////////////////////////////////////////
  // timing counts
  localparam int CLK_MHZ           = 100;       // i_mclk rate
  localparam int TICK_NS           = 320;       // timer tick period in ns
  localparam int TICK_CLKS_DEFAULT = (TICK_NS * CLK_MHZ + 999) / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // opcode encodings and match masks
  localparam logic [7:0] MASK_ALL      = 8'hff;  // whole byte must match
  localparam logic [7:0] MASK_REG      = 8'hf8;  // low three bits pick Rr
  localparam logic [7:0] MASK_IND      = 8'hfe;  // low bit picks R0 or R1
  localparam logic [7:0] OP_MOV_A_REG  = 8'hf8;
  localparam logic [7:0] OP_MOV_A_IND  = 8'hf0;
  localparam logic [7:0] OP_MOV_REG_A  = 8'ha8;
  localparam logic [7:0] OP_MOV_IND_A  = 8'ha0;
  localparam logic [7:0] OP_SWAP_REG   = 8'h28;
  localparam logic [7:0] OP_SWAP_IND   = 8'h20;
  localparam logic [7:0] OP_SWAP_DIGIT = 8'h30;
  localparam logic [7:0] OP_PAGE_LOOK  = 8'ha3;
  localparam logic [7:0] OP_FIXED_LOOK = 8'he3;
  localparam logic [7:0] OP_READ_CNT   = 8'h42;
  localparam logic [7:0] OP_LOAD_CNT   = 8'h62;
  localparam logic [7:0] OP_BEGIN_TIME = 8'h55;
  localparam logic [7:0] OP_BEGIN_EVT  = 8'h45;
  localparam logic [7:0] OP_HALT_CNT   = 8'h65;
  localparam logic [7:0] OP_TIRQ_EN    = 8'h25;
  localparam logic [7:0] OP_TIRQ_DIS   = 8'h35;
  localparam logic [7:0] OP_HIRQ_EN    = 8'h05;
  localparam logic [7:0] OP_HIRQ_DIS   = 8'h15;
  localparam logic [7:0] OP_SUSPEND    = 8'h82;
  localparam logic [7:0] OP_BANK_ZERO  = 8'h63;
  localparam logic [7:0] OP_BANK_ONE   = 8'h73;
  localparam logic [7:0] OP_BRANCH_OVF = 8'h16;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {ST_ADDR, ST_OP, ST_ADDR2, ST_OP2, ST_SUSP} state_t;
  typedef enum logic [1:0] {CNT_STOPPED, CNT_TIMER, CNT_EVENT} count_mode_t;
  typedef struct packed {
    logic timer_irq_enable;  // timer overflow may interrupt
    logic host_irq_enable;   // host input-buffer write may interrupt
  } irq_enables_t;

endpackage : mcu_decode_pkg

// *** hw/slave_mcu_instruction_decode.sv ***
// instruction decode and execution timing for the slave controller core
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// (RULE_01) indirect load: data memory to accumulator, one cycle
// (RULE_02) accumulator and register swap whole, one cycle
// (RULE_03) accumulator swaps with indirect memory byte, one cycle
// (RULE_04) low digits swap only, high digits kept
// (RULE_05) page lookup: current page, accumulator index, two cycles
// (RULE_06) fixed lookup always reads page three, two cycles
// (RULE_07) timer instructions each one cycle
// (RULE_08) dedicated instruction disables timer interrupt
// (RULE_09) host write interrupt enable and disable, one cycle
// (RULE_10) suspend enters power-down, takes two cycles
// (RULE_11) overflow branch tests then clears flag, two cycles
// (RULE_12) bank select for later jumps, one cycle
module slave_mcu_instruction_decode #(
  parameter int DM_WORDS  = 64,                                 // data memory depth
  parameter int TICK_CLKS = mcu_decode_pkg::TICK_CLKS_DEFAULT   // clocks per timer tick
) (
  input  wire logic                        i_mclk,          // core clock
  input  wire logic                        i_resetn,        // async reset, active low
  output logic [mcu_decode_pkg::PC_W-1:0]  o_pm_addr_q,     // program memory address
  input  wire logic [7:0]                  i_pm_data,       // byte at last address
  input  wire logic                        i_host_pending,  // host wrote input buffer (pin)
  input  wire logic                        i_count_pin,     // event counter input (pin)
  output logic [7:0]                       o_acc_q,         // accumulator
  output logic [7:0]                       o_count_q,       // timer/counter value
  output logic                             o_ovf_flag_q,    // timer overflow flag
  output mcu_decode_pkg::irq_enables_t     o_irq_en_q,      // interrupt enables
  output logic                             o_timer_irq_q,   // timer interrupt request
  output logic                             o_host_irq_q,    // host interrupt request
  output logic                             o_code_bank_q,   // program bank for jumps
  output logic                             o_suspend_q,     // suspend power-down active
  output logic                             o_retire_q,      // instruction completed
  output logic [1:0]                       o_cycles_q       // its machine cycles
);

  localparam int DM_AW = $clog2(DM_WORDS);  // data memory address width

  ////////////////////////////////////////////////////////////////////////////
  // state

  mcu_decode_pkg::state_t      state_q;               // sequencer state
  logic [mcu_decode_pkg::PC_W-1:0] pc_q;              // address of current byte
  logic [7:0]                  ir_q;                  // opcode of two-cycle instruction
  logic                        take_q;                // overflow branch decision
  logic [7:0]                  dm_q [DM_WORDS];       // internal data memory
  mcu_decode_pkg::count_mode_t mode_q;                // timer/counter mode
  logic [$clog2(TICK_CLKS+1)-1:0] presc_q;            // timer prescaler
  logic                        host_s1_q;             // host pending synchroniser
  logic                        host_s2_q;
  logic                        cnt_s1_q;              // counter pin synchroniser
  logic                        cnt_s2_q;
  logic                        cnt_s3_q;              // delayed copy for edge find

  ////////////////////////////////////////////////////////////////////////////
  // decode

  // opcode match under a mask
  function automatic logic is_op(input logic [7:0] op, input logic [7:0] pat,
                                 input logic [7:0] mask);
    is_op = (op & mask) == pat;
  endfunction : is_op

  logic             in_op;         // opcode byte is on i_pm_data
  logic             two_cycle;     // opcode needs a second machine cycle
  logic [DM_AW-1:0] reg_addr;      // working register address
  logic [DM_AW-1:0] ind_addr;      // address held in R0 or R1
  logic [7:0]       reg_val;       // working register contents
  logic [7:0]       ind_val;       // indirectly addressed byte
  logic             tick;          // timer/counter advances
  logic             ovf;           // timer/counter wraps this edge
  logic             op_clr_flag;   // overflow branch clears the flag

  // combinational decode of the byte in flight
  always_comb
  begin
    in_op       = state_q == mcu_decode_pkg::ST_OP;
    two_cycle   = is_op(i_pm_data, mcu_decode_pkg::OP_PAGE_LOOK, mcu_decode_pkg::MASK_ALL)
                | is_op(i_pm_data, mcu_decode_pkg::OP_FIXED_LOOK, mcu_decode_pkg::MASK_ALL)
                | is_op(i_pm_data, mcu_decode_pkg::OP_SUSPEND, mcu_decode_pkg::MASK_ALL)
                | is_op(i_pm_data, mcu_decode_pkg::OP_BRANCH_OVF, mcu_decode_pkg::MASK_ALL);
    reg_addr    = DM_AW'(i_pm_data[2:0]);
    ind_addr    = DM_AW'(dm_q[DM_AW'(i_pm_data[0])]);
    reg_val     = dm_q[reg_addr];
    ind_val     = dm_q[ind_addr];
    op_clr_flag = in_op
                & is_op(i_pm_data, mcu_decode_pkg::OP_BRANCH_OVF, mcu_decode_pkg::MASK_ALL);
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: one machine cycle is an address clock then an opcode clock

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q     <= mcu_decode_pkg::ST_ADDR;
      pc_q        <= mcu_decode_pkg::PC_RST;
      o_pm_addr_q <= mcu_decode_pkg::PC_RST;
      ir_q        <= 8'h00;
      take_q      <= 1'b0;
      o_retire_q  <= 1'b0;
      o_cycles_q  <= 2'h0;
      o_suspend_q <= 1'b0;
    end
    else
    begin
      o_retire_q <= 1'b0;
      case (state_q)
        // address already out, byte arrives next
        mcu_decode_pkg::ST_ADDR:
        begin
          state_q <= mcu_decode_pkg::ST_OP;
        end
        // opcode present: one-cycle work ends here
        mcu_decode_pkg::ST_OP:
        begin
          pc_q    <= pc_q + 1'b1;
          ir_q    <= i_pm_data;
          take_q  <= o_ovf_flag_q;  // RULE_11
          if (two_cycle)
          begin
            state_q <= mcu_decode_pkg::ST_ADDR2;
            if (is_op(i_pm_data, mcu_decode_pkg::OP_PAGE_LOOK, mcu_decode_pkg::MASK_ALL))
              o_pm_addr_q <= {pc_q[11:8], o_acc_q};  // RULE_05
            else if (is_op(i_pm_data, mcu_decode_pkg::OP_FIXED_LOOK,
                           mcu_decode_pkg::MASK_ALL))
              o_pm_addr_q <= {mcu_decode_pkg::FIXED_PG, o_acc_q};  // RULE_06
            else
              o_pm_addr_q <= pc_q + 1'b1;
          end
          else
          begin
            state_q     <= mcu_decode_pkg::ST_ADDR;
            o_pm_addr_q <= pc_q + 1'b1;
            o_retire_q  <= 1'b1;
            o_cycles_q  <= 2'h1;
          end
        end
        // second machine cycle, address phase
        mcu_decode_pkg::ST_ADDR2:
        begin
          state_q <= mcu_decode_pkg::ST_OP2;
        end
        // second machine cycle, data phase
        mcu_decode_pkg::ST_OP2:
        begin
          o_retire_q <= 1'b1;
          o_cycles_q <= 2'h2;
          state_q    <= mcu_decode_pkg::ST_ADDR;
          if (ir_q == mcu_decode_pkg::OP_BRANCH_OVF)
          begin
            // branch stays in page, else skip the operand
            if (take_q)
            begin
              pc_q        <= {pc_q[11:8], i_pm_data};  // RULE_11
              o_pm_addr_q <= {pc_q[11:8], i_pm_data};
            end
            else
            begin
              pc_q        <= pc_q + 1'b1;
              o_pm_addr_q <= pc_q + 1'b1;
            end
          end
          else
          begin
            o_pm_addr_q <= pc_q;
            if (ir_q == mcu_decode_pkg::OP_SUSPEND)
            begin
              state_q     <= mcu_decode_pkg::ST_SUSP;  // RULE_10
              o_suspend_q <= 1'b1;
            end
          end
        end
        // power-down until the host writes
        mcu_decode_pkg::ST_SUSP:
        begin
          if (host_s2_q)
          begin
            state_q     <= mcu_decode_pkg::ST_ADDR;
            o_suspend_q <= 1'b0;
          end
        end
        default:
        begin
          state_q <= mcu_decode_pkg::ST_ADDR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_acc_q <= mcu_decode_pkg::ACC_RST;
    else if (in_op)
    begin
      if (is_op(i_pm_data, mcu_decode_pkg::OP_MOV_A_REG, mcu_decode_pkg::MASK_REG))
        o_acc_q <= reg_val;
      else if (is_op(i_pm_data, mcu_decode_pkg::OP_MOV_A_IND, mcu_decode_pkg::MASK_IND))
        o_acc_q <= ind_val;  // RULE_01
      else if (is_op(i_pm_data, mcu_decode_pkg::OP_SWAP_REG, mcu_decode_pkg::MASK_REG))
        o_acc_q <= reg_val;  // RULE_02
      else if (is_op(i_pm_data, mcu_decode_pkg::OP_SWAP_IND, mcu_decode_pkg::MASK_IND))
        o_acc_q <= ind_val;  // RULE_03
      else if (is_op(i_pm_data, mcu_decode_pkg::OP_SWAP_DIGIT, mcu_decode_pkg::MASK_IND))
        o_acc_q <= {o_acc_q[7:4], ind_val[3:0]};  // RULE_04
      else if (is_op(i_pm_data, mcu_decode_pkg::OP_READ_CNT, mcu_decode_pkg::MASK_ALL))
        o_acc_q <= o_count_q;  // RULE_07
    end
    else if (state_q == mcu_decode_pkg::ST_OP2 &&
             (ir_q == mcu_decode_pkg::OP_PAGE_LOOK || ir_q == mcu_decode_pkg::OP_FIXED_LOOK))
      o_acc_q <= i_pm_data;  // RULE_05 RULE_06
  end

  ////////////////////////////////////////////////////////////////////////////
  // data memory: swaps write back in the same edge, nothing half done shows

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int i = 0; i < DM_WORDS; i++)
        dm_q[i] <= mcu_decode_pkg::DM_RST;
    end
    else if (in_op)
    begin
      if (is_op(i_pm_data, mcu_decode_pkg::OP_MOV_REG_A, mcu_decode_pkg::MASK_REG))
        dm_q[reg_addr] <= o_acc_q;
      else if (is_op(i_pm_data, mcu_decode_pkg::OP_MOV_IND_A, mcu_decode_pkg::MASK_IND))
        dm_q[ind_addr] <= o_acc_q;
      else if (is_op(i_pm_data, mcu_decode_pkg::OP_SWAP_REG, mcu_decode_pkg::MASK_REG))
        dm_q[reg_addr] <= o_acc_q;  // RULE_02
      else if (is_op(i_pm_data, mcu_decode_pkg::OP_SWAP_IND, mcu_decode_pkg::MASK_IND))
        dm_q[ind_addr] <= o_acc_q;  // RULE_03
      else if (is_op(i_pm_data, mcu_decode_pkg::OP_SWAP_DIGIT, mcu_decode_pkg::MASK_IND))
        dm_q[ind_addr] <= {ind_val[7:4], o_acc_q[3:0]};  // RULE_04
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, second stage feeds the logic

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      host_s1_q <= 1'b0;
      host_s2_q <= 1'b0;
      cnt_s1_q  <= 1'b0;
      cnt_s2_q  <= 1'b0;
      cnt_s3_q  <= 1'b0;
    end
    else
    begin
      host_s1_q <= i_host_pending;
      host_s2_q <= host_s1_q;
      cnt_s1_q  <= i_count_pin;
      cnt_s2_q  <= cnt_s1_q;
      cnt_s3_q  <= cnt_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer/counter

  // tick source follows the mode, event mode counts falling pin edges
  always_comb
  begin
    tick = 1'b0;
    case (mode_q)
      mcu_decode_pkg::CNT_TIMER: tick = presc_q == ($clog2(TICK_CLKS+1))'(TICK_CLKS - 1);
      mcu_decode_pkg::CNT_EVENT: tick = cnt_s3_q & ~cnt_s2_q;
      default:                   tick = 1'b0;
    endcase
    ovf = tick & (o_count_q == mcu_decode_pkg::CNT_TOP);
  end

  // mode, prescaler and count
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      mode_q    <= mcu_decode_pkg::CNT_STOPPED;
      presc_q   <= '0;
      o_count_q <= mcu_decode_pkg::CNT_RST;
    end
    else
    begin
      presc_q <= (tick || mode_q != mcu_decode_pkg::CNT_TIMER) ? '0 : presc_q + 1'b1;
      if (in_op && is_op(i_pm_data, mcu_decode_pkg::OP_LOAD_CNT, mcu_decode_pkg::MASK_ALL))
        o_count_q <= o_acc_q;  // RULE_07
      else if (tick)
        o_count_q <= o_count_q + 1'b1;
      if (in_op)
      begin
        if (is_op(i_pm_data, mcu_decode_pkg::OP_BEGIN_TIME, mcu_decode_pkg::MASK_ALL))
          mode_q <= mcu_decode_pkg::CNT_TIMER;  // RULE_07
        else if (is_op(i_pm_data, mcu_decode_pkg::OP_BEGIN_EVT, mcu_decode_pkg::MASK_ALL))
          mode_q <= mcu_decode_pkg::CNT_EVENT;  // RULE_07
        else if (is_op(i_pm_data, mcu_decode_pkg::OP_HALT_CNT, mcu_decode_pkg::MASK_ALL))
          mode_q <= mcu_decode_pkg::CNT_STOPPED;  // RULE_07
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags, enables, bank and interrupt requests

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_ovf_flag_q  <= 1'b0;
      o_irq_en_q    <= '0;
      o_code_bank_q <= 1'b0;
      o_timer_irq_q <= 1'b0;
      o_host_irq_q  <= 1'b0;
    end
    else
    begin
      // overflow in the clearing cycle keeps the flag set
      o_ovf_flag_q  <= ovf | (o_ovf_flag_q & ~op_clr_flag);  // RULE_11
      o_timer_irq_q <= o_ovf_flag_q & o_irq_en_q.timer_irq_enable;
      o_host_irq_q  <= host_s2_q & o_irq_en_q.host_irq_enable;
      if (in_op)
      begin
        if (is_op(i_pm_data, mcu_decode_pkg::OP_TIRQ_EN, mcu_decode_pkg::MASK_ALL))
          o_irq_en_q.timer_irq_enable <= 1'b1;  // RULE_07
        if (is_op(i_pm_data, mcu_decode_pkg::OP_TIRQ_DIS, mcu_decode_pkg::MASK_ALL))
          o_irq_en_q.timer_irq_enable <= 1'b0;  // RULE_08
        if (is_op(i_pm_data, mcu_decode_pkg::OP_HIRQ_EN, mcu_decode_pkg::MASK_ALL))
          o_irq_en_q.host_irq_enable <= 1'b1;  // RULE_09
        if (is_op(i_pm_data, mcu_decode_pkg::OP_HIRQ_DIS, mcu_decode_pkg::MASK_ALL))
          o_irq_en_q.host_irq_enable <= 1'b0;  // RULE_09
        if (is_op(i_pm_data, mcu_decode_pkg::OP_BANK_ZERO, mcu_decode_pkg::MASK_ALL))
          o_code_bank_q <= 1'b0;  // RULE_12
        if (is_op(i_pm_data, mcu_decode_pkg::OP_BANK_ONE, mcu_decode_pkg::MASK_ALL))
          o_code_bank_q <= 1'b1;  // RULE_12
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  ind_load_a: assert property (in_op && (i_pm_data & 8'hfe) == 8'hf0 |=> // RULE_01
    o_acc_q == $past(ind_val) && o_retire_q && o_cycles_q == 2'h1)
    else $error("indirect load wrong");
  swap_reg_a: assert property (in_op && (i_pm_data & 8'hf8) == 8'h28 |=> // RULE_02
    o_acc_q == $past(reg_val) && dm_q[$past(reg_addr)] == $past(o_acc_q))
    else $error("register swap wrong");
  swap_ind_a: assert property (in_op && (i_pm_data & 8'hfe) == 8'h20 |=> // RULE_03
    o_acc_q == $past(ind_val) && dm_q[$past(ind_addr)] == $past(o_acc_q))
    else $error("indirect swap wrong");
  swap_digit_a: assert property (in_op && (i_pm_data & 8'hfe) == 8'h30 |=> // RULE_04
    o_acc_q[7:4] == $past(o_acc_q[7:4]) && dm_q[$past(ind_addr)][3:0] == $past(o_acc_q[3:0]))
    else $error("digit swap wrong");
  page_look_a: assert property (in_op && i_pm_data == 8'ha3 |=> // RULE_05
    o_pm_addr_q == {$past(pc_q[11:8]), $past(o_acc_q)} ##2 o_retire_q && o_cycles_q == 2'h2)
    else $error("page lookup wrong");
  fixed_look_a: assert property (in_op && i_pm_data == 8'he3 |=> // RULE_06
    o_pm_addr_q[11:8] == 4'h3 ##1 1'b1 ##1 o_acc_q == $past(i_pm_data))
    else $error("fixed lookup wrong");
  timer_start_a: assert property (in_op && i_pm_data == 8'h55 |=> // RULE_07
    mode_q == mcu_decode_pkg::CNT_TIMER && state_q == mcu_decode_pkg::ST_ADDR)
    else $error("timer start wrong");
  timer_irq_off_a: assert property (in_op && i_pm_data == 8'h35 |=> // RULE_08
    !o_irq_en_q.timer_irq_enable ##1 !o_timer_irq_q) else $error("timer irq not off");
  host_irq_on_a: assert property (in_op && i_pm_data == 8'h05 |=> // RULE_09
    o_irq_en_q.host_irq_enable && o_cycles_q == 2'h1) else $error("host irq not on");
  suspend_enter_a: assert property (in_op && i_pm_data == 8'h82 |=> // RULE_10
    !o_suspend_q ##2 o_suspend_q && o_cycles_q == 2'h2) else $error("suspend wrong");
  ovf_clear_a: assert property (op_clr_flag && !ovf |=> !o_ovf_flag_q) // RULE_11
    else $error("overflow flag not cleared");
  bank_one_a: assert property (in_op && i_pm_data == 8'h73 |=> // RULE_12
    o_code_bank_q && o_retire_q) else $error("bank select wrong");

  suspend_c: cover property (o_suspend_q ##1 !o_suspend_q);
  branch_c:  cover property (op_clr_flag && o_ovf_flag_q);
  look_c:    cover property (state_q == mcu_decode_pkg::ST_OP2 && ir_q == 8'ha3);

endmodule : slave_mcu_instruction_decode
`default_nettype wire

// *** sim/prog_mem_model.sv ***
// program memory model that answers the decoder's opcode fetches
`timescale 1ns/1ns
`default_nettype none
module prog_mem_model (
  input  wire logic [11:0] i_addr,  // registered fetch address
  output logic      [7:0]  o_data   // byte at that address
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] mem [0:4095];  // code bytes, loaded by the bench
  // combinational read: the byte settles well before the next edge
  assign o_data = mem[i_addr];
endmodule : prog_mem_model
`default_nettype wire

// *** sim/test_slave_mcu_instruction_decode.sv ***
// self-checking bench for the instruction decoder
`timescale 1ns/1ns
`default_nettype none
module test_slave_mcu_instruction_decode;
  ////////////////////////////////////////////////////////////////////////////
  localparam int N_ROWS = 22;  // ordinary cases, one instruction each
  // row: opcode, accumulator, cycles, irq enables, code bank (hex nibbles)
  localparam logic [27:0] ROWS [N_ROWS] = '{
    28'he305200, 28'ha805100, 28'he3a7200, 28'ha0a7100, 28'he33c200,
    28'h3037100, 28'h20ac100, 28'hf037100, 28'h2805100, 28'hf837100,
    28'ha35e200, 28'h625e100, 28'h255e120, 28'h055e130, 28'h735e131,
    28'h635e130, 28'he3fe230, 28'h62fe130, 28'h55fe130, 28'h35fe110,
    28'h15fe100, 28'h16fe200};
  logic                         mclk = 1'b0; // core clock
  logic                         resetn;     // reset, active low
  logic [11:0]                  pm_addr;    // fetch address
  logic [7:0]                   pm_data;    // fetched byte
  logic                         host;       // host write pending pin
  logic                         pin;        // event counter pin
  logic [7:0]                   acc;        // accumulator
  logic [7:0]                   count;      // timer/counter
  logic                         ovf;        // overflow flag
  mcu_decode_pkg::irq_enables_t irq_en;     // interrupt enables
  logic                         timer_irq;  // timer request
  logic                         host_irq;   // host request
  logic                         bank;       // code bank
  logic                         suspend;    // power-down active
  logic                         retire;     // completion pulse
  logic [1:0]                   cycles;     // cycles of last instruction
  int                           n_errors;   // mismatches
  int                           num_checks; // comparisons
  int                           k;          // bounded wait counter
  ////////////////////////////////////////////////////////////////////////////
  // short timer tick keeps the overflow case quick
  slave_mcu_instruction_decode #(
    .TICK_CLKS (2)
  ) u_slave_mcu_instruction_decode (
    .i_mclk         (mclk),
    .i_resetn       (resetn),
    .o_pm_addr_q    (pm_addr),
    .i_pm_data      (pm_data),
    .i_host_pending (host),
    .i_count_pin    (pin),
    .o_acc_q        (acc),
    .o_count_q      (count),
    .o_ovf_flag_q   (ovf),
    .o_irq_en_q     (irq_en),
    .o_timer_irq_q  (timer_irq),
    .o_host_irq_q   (host_irq),
    .o_code_bank_q  (bank),
    .o_suspend_q    (suspend),
    .o_retire_q     (retire),
    .o_cycles_q     (cycles)
  );
  prog_mem_model u_prog_mem_model (
    .i_addr (pm_addr),
    .o_data (pm_data)
  );
  always #5 mclk = ~mclk;  // 100 MHz
  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  // wait for the next completion pulse, bounded
  task automatic wait_retire;
    @(negedge mclk);
    for (k = 0; k < 20 && retire !== 1'b1; k++) @(negedge mclk);
    check("retire", {11'h0, retire}, 12'h1);
  endtask : wait_retire
  // one high-then-low pulse on the counter pin
  task automatic pulse;
    @(posedge mclk) pin <= 1'b1;
    repeat (6) @(posedge mclk);
    pin <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask : pulse
  // verdict and end of run
  task automatic end_of_test;
    $display("checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial
  begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    end_of_test();
  end
  // main sequence
  initial
  begin
    resetn     = 1'b0;
    host       = 1'b0;
    pin        = 1'b0;
    n_errors   = 0;
    num_checks = 0;
    for (int a = 0; a < 4096; a++) u_prog_mem_model.mem[a] = 8'h00;
    for (int r = 0; r < N_ROWS; r++) u_prog_mem_model.mem[r] = ROWS[r][27:20];
    u_prog_mem_model.mem[22] = 8'h40;  // branch target byte
    u_prog_mem_model.mem[12'h040] = 8'h82;
    u_prog_mem_model.mem[12'h041] = 8'h45;
    u_prog_mem_model.mem[12'h042] = 8'h62;
    u_prog_mem_model.mem[12'h060] = 8'h65;
    u_prog_mem_model.mem[12'h061] = 8'h42;  // read the halted count
    u_prog_mem_model.mem[12'h062] = 8'h16;  // taken: event wrap left the flag set
    u_prog_mem_model.mem[12'h063] = 8'h70;
    u_prog_mem_model.mem[12'h070] = 8'h16;  // not taken: flag now clear
    u_prog_mem_model.mem[12'h072] = 8'h82;  // park in suspend after the skip
    u_prog_mem_model.mem[12'h037] = 8'h5e;  // current page table
    u_prog_mem_model.mem[12'h300] = 8'h05;  // fixed page table
    u_prog_mem_model.mem[12'h305] = 8'ha7;
    u_prog_mem_model.mem[12'h3a7] = 8'h3c;
    u_prog_mem_model.mem[12'h35e] = 8'hfe;
    repeat (3) @(negedge mclk);
    check("reset addr", pm_addr, 12'h000);
    check("reset state", {acc, irq_en, bank, suspend}, 12'h000);
    @(posedge mclk) resetn <= 1'b1;
    // ordinary cases
    for (int r = 0; r < N_ROWS; r++)
    begin
      wait_retire();
      check("acc", {4'h0, acc}, {4'h0, ROWS[r][19:12]});
      check("cycles", {10'h0, cycles}, {10'h0, ROWS[r][9:8]});
      check("irq enables", {10'h0, irq_en}, {10'h0, ROWS[r][5:4]});
      check("code bank", {11'h0, bank}, {11'h0, ROWS[r][0]});
      if (ROWS[r][27:20] == 8'h62) check("count", {4'h0, count}, {4'h0, ROWS[r][19:12]});
    end
    // the overflow branch is taken and clears the flag
    check("branch target", pm_addr, 12'h040);
    check("overflow flag", {11'h0, ovf}, 12'h000);
    // suspend: two cycles, no fetch until the host writes
    wait_retire();
    check("suspend cycles", {10'h0, cycles}, 12'h002);
    repeat (20) @(negedge mclk);
    check("suspended", {suspend, pm_addr[10:0]}, 12'h841);
    @(posedge mclk) host <= 1'b1;
    for (k = 0; k < 10 && suspend !== 1'b0; k++) @(negedge mclk);
    check("wake", {10'h0, host_irq, suspend}, 12'h000);
    @(posedge mclk) host <= 1'b0;
    // event counting wraps and sets the flag; disabled timer irq stays low
    wait_retire();
    wait_retire();
    check("loaded count", {4'h0, count}, 12'h0fe);
    repeat (3) pulse();
    repeat (8) @(negedge mclk);
    check("event count", {2'h0, timer_irq, ovf, count}, 12'h101);
    // halt stops counting
    for (k = 0; k < 100 && pm_addr !== 12'h061; k++) @(negedge mclk);
    pulse();
    repeat (8) @(negedge mclk);
    check("halted count", {4'h0, count}, 12'h001);
    check("read count", {4'h0, acc}, 12'h001);
    // taken branch clears the flag, the next one falls through to suspend
    check("skip branch", {ovf, suspend, pm_addr[9:0]}, 12'h473);
    // reset in mid-run clears suspend, flag, accumulator and the low two fetch address bits
    @(posedge mclk) resetn <= 1'b0;
    @(negedge mclk);
    check("mid reset", {suspend, ovf, acc, pm_addr[1:0]}, 12'h000);
    end_of_test();
  end
endmodule : test_slave_mcu_instruction_decode
`default_nettype wire
